// >>> fesc_defines.svh
// constants for the flash erase-suspend command controller
`ifndef FESC_DEFINES_SVH
`define FESC_DEFINES_SVH

// clock, bus-cycle and suspend timing
`define FESC_CLK_MHZ         25
`define FESC_T_SETUP_NS      40
`define FESC_T_PULSE_NS      80
`define FESC_T_SUSPEND_US    20

// flash pin widths
`define FESC_AW              18
`define FESC_DW              16

// register byte offsets on the wishbone side
`define FESC_REG_CMD         8'h00
`define FESC_REG_ADDR        8'h04
`define FESC_REG_WDATA       8'h08
`define FESC_REG_RDATA       8'h0c
`define FESC_REG_STATUS      8'h10

// status register bit positions
`define FESC_ST_BUSY         0
`define FESC_ST_SUSP         1
`define FESC_ST_TMO          2
`define FESC_ST_BYPASS       3
`define FESC_ST_AUTOSEL      4

// command field of the cmd register
`define FESC_CMD_LSB         0
`define FESC_CMD_MSB         3

// unlock addresses and command data
`define FESC_UNLOCK1_ADDR    11'h555
`define FESC_UNLOCK2_ADDR    11'h2aa
`define FESC_UNLOCK1_DATA    8'haa
`define FESC_UNLOCK2_DATA    8'h55
`define FESC_D_RESET         8'hf0
`define FESC_D_AUTOSEL       8'h90
`define FESC_D_PROGRAM       8'ha0
`define FESC_D_BYPASS        8'h20
`define FESC_D_BYP_EXIT1     8'h90
`define FESC_D_BYP_EXIT2     8'h00
`define FESC_D_ERASE_SETUP   8'h80
`define FESC_D_SECT_ERASE    8'h30
`define FESC_D_SUSPEND       8'hb0
`define FESC_D_RESUME        8'h30

// status bit position on the flash data lines
`define FESC_TMO_BIT         5

`endif

// >>> fesc_pkg.sv
// types shared by the flash erase-suspend command controller
package fesc_pkg;

  // software-visible command codes
  typedef enum logic [3:0] {
    FESC_OP_READ    = 4'h0,
    FESC_OP_RESET   = 4'h1,
    FESC_OP_AUTOSEL = 4'h2,
    FESC_OP_PROGRAM = 4'h3,
    FESC_OP_BYP_ENT = 4'h4,
    FESC_OP_BYP_PRG = 4'h5,
    FESC_OP_BYP_EXT = 4'h6,
    FESC_OP_SE      = 4'h7,
    FESC_OP_SUSPEND = 4'h8,
    FESC_OP_RESUME  = 4'h9
  } fesc_op_e;

  // sequencer states
  typedef enum logic [1:0] {
    FESC_ST_IDLE = 2'b00,
    FESC_ST_RUN  = 2'b01,
    FESC_ST_WAIT = 2'b10
  } fesc_state_e;

  // one bus cycle of a command sequence
  typedef struct packed {
    logic        rd;
    logic        use_tgt;
    logic        use_wdata;
    logic        last;
    logic [10:0] addr;
    logic [7:0]  data;
  } fesc_step_s;

  // request handed to the bus-cycle engine
  typedef struct packed {
    logic        rd;
    logic [17:0] addr;
    logic [15:0] data;
  } fesc_req_s;

endpackage : fesc_pkg

// >>> fesc_wait.sv
// down-counter that signals the end of a fixed wait
`include "fesc_defines.svh"

module fesc_wait #(
  parameter int CYCLES = 1
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // control
  input  wire logic start_i,
  output logic      done_o
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_r;
  logic          run_r;

  // load on start, pulse done when the count runs out
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r  <= '0;
      run_r  <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        cnt_r <= CW'(CYCLES);
        run_r <= 1'b1;
      end else if (run_r) begin
        if (cnt_r <= CW'(1)) begin
          run_r  <= 1'b0;
          done_o <= 1'b1;
        end
        cnt_r <= cnt_r - CW'(1);
      end
    end
  end

endmodule : fesc_wait

// >>> fesc_bus_cycle.sv
// one asynchronous flash bus cycle, read or write, from registered pins
`include "fesc_defines.svh"

module fesc_bus_cycle (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // request side
  input  wire logic                 start_i,
  input  wire fesc_pkg::fesc_req_s  req_i,
  output logic                      done_o,
  output logic [`FESC_DW-1:0]       rdata_o,
  // flash pins
  output logic [`FESC_AW-1:0]       fl_addr_o,
  output logic [`FESC_DW-1:0]       fl_dq_o,
  output logic                      fl_dq_oe_o,
  input  wire logic [`FESC_DW-1:0]  fl_dq_i,
  output logic                      fl_ce_n_o,
  output logic                      fl_we_n_o,
  output logic                      fl_oe_n_o
);

  localparam int SETUP = (`FESC_T_SETUP_NS * `FESC_CLK_MHZ + 999) / 1000;
  localparam int PULSE = (`FESC_T_PULSE_NS * `FESC_CLK_MHZ + 999) / 1000;
  localparam int TOTAL = SETUP + PULSE;

  logic [3:0] ph_r;
  logic       act_r;
  logic       rd_r;

  // phase counter: setup with chip select low, then the strobe pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_r  <= 4'h0;
      act_r <= 1'b0;
      rd_r  <= 1'b0;
    end else if (start_i && !act_r) begin
      ph_r  <= 4'h0;
      act_r <= 1'b1;
      rd_r  <= req_i.rd;
    end else if (act_r) begin
      ph_r <= ph_r + 4'h1;
      if (ph_r == 4'(TOTAL)) begin
        act_r <= 1'b0;
      end
    end
  end

  // pins; device latches address on strobe fall, data on strobe rise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fl_addr_o  <= '0;
      fl_dq_o    <= '0;
      fl_dq_oe_o <= 1'b0;
      fl_ce_n_o  <= 1'b1;
      fl_we_n_o  <= 1'b1;
      fl_oe_n_o  <= 1'b1;
    end else if (start_i && !act_r) begin
      fl_addr_o  <= req_i.addr;
      fl_dq_o    <= req_i.data;
      fl_dq_oe_o <= !req_i.rd;
      fl_ce_n_o  <= 1'b0;
    end else if (act_r) begin
      if (ph_r == 4'(SETUP - 1)) begin
        fl_we_n_o <= rd_r;
        fl_oe_n_o <= !rd_r;
      end else if (ph_r == 4'(TOTAL - 1)) begin
        fl_we_n_o <= 1'b1; // data held past the rising strobe
        fl_oe_n_o <= 1'b1;
      end else if (ph_r == 4'(TOTAL)) begin
        fl_ce_n_o  <= 1'b1;
        fl_dq_oe_o <= 1'b0;
      end
    end
  end

  // read data sampled in the last strobe cycle, done on release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
      done_o  <= 1'b0;
    end else begin
      done_o <= act_r && (ph_r == 4'(TOTAL));
      if (act_r && rd_r && ph_r == 4'(TOTAL - 1)) begin
        rdata_o <= fl_dq_i;
      end
    end
  end

endmodule : fesc_bus_cycle

// >>> fesc_ctrl.sv
// host-side command sequencer for a parallel nor flash, wishbone controlled
`include "fesc_defines.svh"

// Contract
// - wait 20 us after suspend
// - suspend is one write of b0
// - resume is one write of 30
// - array read is single read cycle
// - reset f0 leaves autoselect, timeout error
// - all command cycles are writes
// - top six address bits select sector
// - program: aa/555, 55/2aa, a0/555, data
// - bypass entered with unlock then 20
// - bypass left with 90 then 00
module fesc_ctrl (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // wishbone slave
  input  wire logic                cyc_i,
  input  wire logic                stb_i,
  input  wire logic                we_i,
  input  wire logic [7:0]          adr_i,
  input  wire logic [3:0]          sel_i,
  input  wire logic [31:0]         dat_i,
  output logic [31:0]              dat_o,
  output logic                     ack_o,
  // flash pins
  output logic [`FESC_AW-1:0]      fl_addr_o,
  output logic [`FESC_DW-1:0]      fl_dq_o,
  output logic                     fl_dq_oe_o,
  input  wire logic [`FESC_DW-1:0] fl_dq_i,
  output logic                     fl_ce_n_o,
  output logic                     fl_we_n_o,
  output logic                     fl_oe_n_o
);

  // worst-case suspend latency in clock cycles; a window suspend needs less,
  // but the host cannot tell the two apart, so it always waits the full time
  localparam int SUSP_CYC = `FESC_T_SUSPEND_US * `FESC_CLK_MHZ;

  // sequencer state and the operands of the running command
  fesc_pkg::fesc_op_e    op_r;
  fesc_pkg::fesc_state_e state_r;
  fesc_pkg::fesc_step_s  step;
  fesc_pkg::fesc_req_s   req;
  logic [2:0]            idx_r;
  logic [`FESC_AW-1:0]   addr_r;
  logic [`FESC_DW-1:0]   wdata_r;
  logic [`FESC_DW-1:0]   rdata_r;
  logic [`FESC_DW-1:0]   bc_rdata;
  logic                  bc_start_r;
  logic                  bc_done;
  logic                  wait_start_r;
  logic                  wait_done;
  logic                  susp_r;
  logic                  tmo_r;
  logic                  byp_r;
  logic                  autosel_r;
  logic                  wb_req;
  logic                  cmd_wr;

  // one bus cycle of each command sequence, word mode
  // index i counts bus cycles from zero; last marks the final one
  function automatic fesc_pkg::fesc_step_s step_of(input fesc_pkg::fesc_op_e op,
                                                   input logic [2:0] i);
    fesc_pkg::fesc_step_s s;
    logic [7:0]           cmd;
    logic                 erase;
    s    = '0;
    cmd  = `FESC_D_RESET;
    erase = (op == fesc_pkg::FESC_OP_SE);
    case (op)
      fesc_pkg::FESC_OP_AUTOSEL: cmd = `FESC_D_AUTOSEL;
      fesc_pkg::FESC_OP_PROGRAM: cmd = `FESC_D_PROGRAM;
      fesc_pkg::FESC_OP_BYP_ENT: cmd = `FESC_D_BYPASS;
      default:                   cmd = `FESC_D_ERASE_SETUP;
    endcase
    case (op)
      fesc_pkg::FESC_OP_READ: begin
        s.rd      = 1'b1;
        s.use_tgt = 1'b1;
        s.last    = 1'b1;
      end
      fesc_pkg::FESC_OP_RESET: begin
        s.data = `FESC_D_RESET;
        s.last = 1'b1;
      end
      fesc_pkg::FESC_OP_SUSPEND: begin
        s.data = `FESC_D_SUSPEND;
        s.last = 1'b1;
      end
      fesc_pkg::FESC_OP_RESUME: begin
        s.data = `FESC_D_RESUME;
        s.last = 1'b1;
      end
      fesc_pkg::FESC_OP_BYP_PRG: begin
        if (i == 3'd0) begin
          s.data = `FESC_D_PROGRAM;
        end else begin
          s.use_tgt   = 1'b1;
          s.use_wdata = 1'b1;
          s.last      = 1'b1;
        end
      end
      fesc_pkg::FESC_OP_BYP_EXT: begin
        s.data = (i == 3'd0) ? `FESC_D_BYP_EXIT1 : `FESC_D_BYP_EXIT2;
        s.last = (i != 3'd0);
      end
      default: begin
        // unlock pair, then command; only sector erase repeats the pair,
        // so the fourth cycle of program and autoselect is the target access
        if (i == 3'd0 || (erase && i == 3'd3)) begin
          s.addr = `FESC_UNLOCK1_ADDR;
          s.data = `FESC_UNLOCK1_DATA;
        end else if (i == 3'd1 || (erase && i == 3'd4)) begin
          s.addr = `FESC_UNLOCK2_ADDR;
          s.data = `FESC_UNLOCK2_DATA;
        end else if (i == 3'd2) begin
          s.addr = `FESC_UNLOCK1_ADDR;
          s.data = cmd;
          s.last = (op == fesc_pkg::FESC_OP_BYP_ENT);
        end else if (op == fesc_pkg::FESC_OP_AUTOSEL) begin
          s.rd      = 1'b1;
          s.use_tgt = 1'b1;
          s.last    = 1'b1;
        end else if (op == fesc_pkg::FESC_OP_PROGRAM) begin
          s.use_tgt   = 1'b1;
          s.use_wdata = 1'b1;
          s.last      = 1'b1;
        end else begin
          s.use_tgt = 1'b1;
          s.data    = `FESC_D_SECT_ERASE;
          s.last    = 1'b1;
        end
      end
    endcase
    return s;
  endfunction : step_of

  // current step turned into a pin-level request; upper bits zero
  // unlock and command cycles drive zero on the bits the device ignores,
  // only target accesses carry the full address, and only program targets carry the full data word
  always_comb begin
    step      = step_of(op_r, idx_r);
    req.rd    = step.rd;
    req.addr  = step.use_tgt ? addr_r : {7'h00, step.addr};
    req.data  = step.use_wdata ? wdata_r : {8'h00, step.data};
  end

  // a request is taken once; the ack cycle itself is not a new request
  assign wb_req = cyc_i && stb_i && !ack_o;
  assign cmd_wr = wb_req && we_i && sel_i[0] && adr_i == `FESC_REG_CMD;

  // wishbone answer one cycle after the request, dropped the next
  // ack straight from a flip-flop costs one wait state per access
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= wb_req;
      dat_o <= 32'h0000_0000;
      if (wb_req && !we_i) begin
        if (adr_i == `FESC_REG_CMD) begin
          dat_o <= {28'h000_0000, op_r};
        end else if (adr_i == `FESC_REG_ADDR) begin
          dat_o <= {14'h0000, addr_r};
        end else if (adr_i == `FESC_REG_WDATA) begin
          dat_o <= {16'h0000, wdata_r};
        end else if (adr_i == `FESC_REG_RDATA) begin
          dat_o <= {16'h0000, rdata_r};
        end else if (adr_i == `FESC_REG_STATUS) begin
          dat_o[`FESC_ST_BUSY]    <= state_r != fesc_pkg::FESC_ST_IDLE;
          dat_o[`FESC_ST_SUSP]    <= susp_r;
          dat_o[`FESC_ST_TMO]     <= tmo_r;
          dat_o[`FESC_ST_BYPASS]  <= byp_r;
          dat_o[`FESC_ST_AUTOSEL] <= autosel_r;
        end
      end
    end
  end

  // address and write-data registers, frozen while a sequence runs
  // writes while busy are acked but dropped, so a running target never moves
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_r  <= '0;
      wdata_r <= '0;
    end else if (wb_req && we_i && state_r == fesc_pkg::FESC_ST_IDLE) begin
      if (adr_i == `FESC_REG_ADDR) begin
        addr_r <= dat_i[`FESC_AW-1:0];
      end else if (adr_i == `FESC_REG_WDATA) begin
        wdata_r <= dat_i[`FESC_DW-1:0];
      end
    end
  end

  // sequencer: steps through bus cycles, then the suspend wait
  // a command written while busy is acked and lost; software polls busy first
  // only a suspend ends in the wait state, every other command returns to idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r      <= fesc_pkg::FESC_ST_IDLE;
      op_r         <= fesc_pkg::FESC_OP_READ;
      idx_r        <= 3'd0;
      bc_start_r   <= 1'b0;
      wait_start_r <= 1'b0;
    end else begin
      bc_start_r   <= 1'b0;
      wait_start_r <= 1'b0;
      case (state_r)
        fesc_pkg::FESC_ST_IDLE: begin
          // commands written while busy are dropped
          if (cmd_wr) begin
            op_r       <= fesc_pkg::fesc_op_e'(dat_i[`FESC_CMD_MSB:`FESC_CMD_LSB]);
            idx_r      <= 3'd0;
            bc_start_r <= 1'b1;
            state_r    <= fesc_pkg::FESC_ST_RUN;
          end
        end
        fesc_pkg::FESC_ST_RUN: begin
          if (bc_done) begin
            if (!step.last) begin
              // next step starts after done, leaving a two-clock gap
              idx_r      <= idx_r + 3'd1;
              bc_start_r <= 1'b1;
            end else if (op_r == fesc_pkg::FESC_OP_SUSPEND) begin
              wait_start_r <= 1'b1;
              state_r      <= fesc_pkg::FESC_ST_WAIT;
            end else begin
              state_r <= fesc_pkg::FESC_ST_IDLE;
            end
          end
        end
        fesc_pkg::FESC_ST_WAIT: begin
          // worst-case suspend latency; a window suspend is quicker
          if (wait_done) begin
            state_r <= fesc_pkg::FESC_ST_IDLE;
          end
        end
        default: begin
          state_r <= fesc_pkg::FESC_ST_IDLE;
        end
      endcase
    end
  end

  // read result and timeout-error bit seen on status reads
  // the timeout bit means something only on status reads; reset clears it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_r <= '0;
      tmo_r   <= 1'b0;
    end else if (bc_done && step.rd) begin
      rdata_r <= bc_rdata;
      tmo_r   <= bc_rdata[`FESC_TMO_BIT];
    end else if (bc_done && op_r == fesc_pkg::FESC_OP_RESET) begin
      tmo_r <= 1'b0;
    end
  end

  // mode tracking of the device as seen from the host
  // flags follow the commands sent, not the device's answers: a suspend sent
  // outside a sector erase still sets the flag, though the device ignores it;
  // reset leaves the suspended flag alone, since the erase is still held
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      susp_r    <= 1'b0;
      byp_r     <= 1'b0;
      autosel_r <= 1'b0;
    end else begin
      if (state_r == fesc_pkg::FESC_ST_WAIT && wait_done) begin
        susp_r <= 1'b1;
      end
      if (bc_done && step.last) begin
        case (op_r)
          fesc_pkg::FESC_OP_RESUME: begin
            susp_r <= 1'b0;
          end
          fesc_pkg::FESC_OP_AUTOSEL: begin
            autosel_r <= 1'b1;
          end
          fesc_pkg::FESC_OP_RESET: begin
            autosel_r <= 1'b0;
          end
          fesc_pkg::FESC_OP_BYP_ENT: begin
            byp_r <= 1'b1;
          end
          fesc_pkg::FESC_OP_BYP_EXT: begin
            byp_r <= 1'b0;
          end
          default: begin
            byp_r <= byp_r;
          end
        endcase
      end
    end
  end

  // pin-level engine; strobe timing lives there
  // one request at a time; the next start waits for done
  fesc_bus_cycle u_cycle (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .start_i    (bc_start_r),
    .req_i      (req),
    .done_o     (bc_done),
    .rdata_o    (bc_rdata),
    .fl_addr_o  (fl_addr_o),
    .fl_dq_o    (fl_dq_o),
    .fl_dq_oe_o (fl_dq_oe_o),
    .fl_dq_i    (fl_dq_i),
    .fl_ce_n_o  (fl_ce_n_o),
    .fl_we_n_o  (fl_we_n_o),
    .fl_oe_n_o  (fl_oe_n_o)
  );

  // suspend latency timer
  // restarted by each suspend; nothing else uses it
  fesc_wait #(
    .CYCLES (SUSP_CYC)
  ) u_wait (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (wait_start_r),
    .done_o  (wait_done)
  );

endmodule : fesc_ctrl

// >>> fesc_ctrl_props.sv
// port assertions for the flash erase-suspend controller
`include "fesc_defines.svh"

module fesc_ctrl_props (
  // clock and reset
  input wire logic                clk_i,
  input wire logic                rst_i,
  // wishbone
  input wire logic                cyc_i,
  input wire logic                stb_i,
  input wire logic [31:0]         dat_o,
  input wire logic                ack_o,
  // flash pins
  input wire logic [`FESC_AW-1:0] fl_addr_o,
  input wire logic [`FESC_DW-1:0] fl_dq_o,
  input wire logic                fl_dq_oe_o,
  input wire logic                fl_ce_n_o,
  input wire logic                fl_we_n_o,
  input wire logic                fl_oe_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acked next cycle");
  a_dat_quiet: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack cycle");
  a_ce_four: assert property ($fell(fl_ce_n_o) |-> !fl_ce_n_o [*4] ##1 fl_ce_n_o)
    else $error("chip enable not low four cycles");
  // strobe falls one cycle into the cycle and stays low two cycles
  a_strobe_shape: assert property ($fell(fl_ce_n_o) |=>
    ($fell(fl_we_n_o) || $fell(fl_oe_n_o)) ##1 (!fl_we_n_o || !fl_oe_n_o)
    ##1 (fl_we_n_o && fl_oe_n_o))
    else $error("strobe pulse misplaced");
  a_strobe_in_ce: assert property (!fl_we_n_o || !fl_oe_n_o |-> !fl_ce_n_o)
    else $error("strobe outside chip enable");
  a_addr_hold: assert property (!fl_ce_n_o && !$fell(fl_ce_n_o) |->
    $stable(fl_addr_o) && $stable(fl_dq_o))
    else $error("address or data moved in cycle");
  a_drive_dir: assert property (!fl_we_n_o |-> fl_dq_oe_o && fl_oe_n_o)
    else $error("write strobe without driving data");
  a_dq_release: assert property ($rose(fl_ce_n_o) |-> !fl_dq_oe_o && fl_oe_n_o)
    else $error("data lines still driven after cycle");
endmodule : fesc_ctrl_props

bind fesc_ctrl fesc_ctrl_props u_props (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o),
  .ack_o(ack_o), .fl_addr_o(fl_addr_o), .fl_dq_o(fl_dq_o), .fl_dq_oe_o(fl_dq_oe_o),
  .fl_ce_n_o(fl_ce_n_o), .fl_we_n_o(fl_we_n_o), .fl_oe_n_o(fl_oe_n_o)
);

// >>> fesc_flash_model.sv
// behavioural parallel nor flash with sector erase and erase suspend
module fesc_flash_model #(
  parameter logic [15:0] ID_CODE = 16'h5a5a  // arbitrary identification value
) (
  input  wire logic [17:0] addr_i,
  input  wire logic [15:0] dq_i,
  input  wire logic        ce_n_i,
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i,
  output logic [15:0]      dq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [logic [17:0]];
  logic [7:0]  d;
  logic [5:0]  esect;
  logic [15:0] drv = 16'h0;
  int          step = 0;
  logic        erasing = 0, susp = 0, autosel = 0, bypass = 0, prog = 0, byp_exit = 0;
  logic        tgl_dev = 0, tgl_sec = 0;

  // commands latch on the rising write strobe; address is still stable then
  always @(posedge we_n_i) begin
    if (!ce_n_i) begin
      d = dq_i[7:0];
      if (prog) begin
        mem[addr_i] = dq_i;
        prog = 0;
      end else if (byp_exit) begin
        bypass = (d != 8'h00);
        byp_exit = 0;
      end else if (bypass) begin
        prog = (d == 8'ha0);
        byp_exit = (d == 8'h90);
      end else if (d == 8'hf0) begin
        autosel = 0;
        step = 0;
      end else if (erasing && !susp) begin
        susp = (d == 8'hb0);
      end else if (step == 0 && d == 8'h30) begin
        susp = 0;
      end else if (step == 0 || step == 3) begin
        step = (d == 8'haa && addr_i[10:0] == 11'h555) ? step + 1 : 0;
      end else if (step == 1 || step == 4) begin
        step = (d == 8'h55 && addr_i[10:0] == 11'h2aa) ? step + 1 : 0;
      end else if (step == 2) begin
        autosel = (d == 8'h90);
        prog = (d == 8'ha0);
        bypass = (d == 8'h20);
        step = (d == 8'h80) ? 3 : 0;
      end else begin
        if (d == 8'h30) begin
          erasing = 1;
          esect = addr_i[17:12];
        end
        step = 0;
      end
    end
  end

  // read data chosen as output enable falls; a released bus shows the inverse
  always @(negedge oe_n_i) begin
    if (!ce_n_i) begin
      if (autosel) begin
        drv = (addr_i[7:0] == 8'h02) ? 16'h0000 : ID_CODE;
      end else if (erasing && addr_i[17:12] == esect) begin
        tgl_sec = ~tgl_sec;
        if (!susp) tgl_dev = ~tgl_dev;
        drv = {8'h00, susp, tgl_dev, 3'b000, tgl_sec, 2'b00};
      end else begin
        drv = mem.exists(addr_i) ? mem[addr_i] : 16'hffff;
      end
    end
  end
  always @(posedge oe_n_i) drv = ~drv;
  assign dq_o = drv;
endmodule : fesc_flash_model

// >>> fesc_ctrl_tb.sv
// self-checking bench for the flash erase-suspend controller
`include "fesc_defines.svh"

module fesc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, st, q, q2;
  logic        ack_o, fl_dq_oe_o, fl_ce_n_o, fl_we_n_o, fl_oe_n_o;
  logic [17:0] fl_addr_o, a;
  logic [15:0] fl_dq_o, fl_dq_i, flash_dq, d;
  logic [5:0]  es;
  int          seed, miscompares, checks_done;

  always #20 clk_i = ~clk_i;
  // the wire level: controller drives on writes, flash otherwise
  assign fl_dq_i = fl_dq_oe_o ? fl_dq_o : flash_dq;

  fesc_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .fl_addr_o(fl_addr_o), .fl_dq_o(fl_dq_o), .fl_dq_oe_o(fl_dq_oe_o), .fl_dq_i(fl_dq_i),
    .fl_ce_n_o(fl_ce_n_o), .fl_we_n_o(fl_we_n_o), .fl_oe_n_o(fl_oe_n_o));
  fesc_flash_model flash (.addr_i(fl_addr_o), .dq_i(fl_dq_i), .ce_n_i(fl_ce_n_o),
    .we_n_i(fl_we_n_o), .oe_n_i(fl_oe_n_o), .dq_o(flash_dq));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // expected array word, zero-extended into a register word
  function automatic logic [31:0] word_of(input logic [15:0] v);
    return {16'h0, v};
  endfunction : word_of

  // one classic wishbone cycle; hold until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                    output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= ad;
    dat_i <= wd;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (ack_o !== 1'b1) begin
      miscompares++;
      print_verdict();
    end
  endtask : wb

  // issue one command and poll status until the sequencer is idle
  task automatic cmd(input fesc_pkg::fesc_op_e op, input logic [17:0] ad,
                     input logic [15:0] wd);
    int n;
    wb(1'b1, `FESC_REG_ADDR, {14'h0, ad}, st);
    wb(1'b1, `FESC_REG_WDATA, {16'h0, wd}, st);
    wb(1'b1, `FESC_REG_CMD, {28'h0, op}, st);
    n = 0;
    do begin
      wb(1'b0, `FESC_REG_STATUS, 32'h0, st);
      n++;
    end while (st[`FESC_ST_BUSY] !== 1'b0 && n < 400);
    if (n >= 400) begin
      miscompares++;
      print_verdict();
    end
  endtask : cmd

  task automatic rd_flash(input logic [17:0] ad, output logic [31:0] rd);
    cmd(fesc_pkg::FESC_OP_READ, ad, 16'h0);
    wb(1'b0, `FESC_REG_RDATA, 32'h0, rd);
  endtask : rd_flash

  initial begin
    seed = 52;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `FESC_REG_STATUS, 32'h0, q);
    check("status", q, 32'h0);
    wb(1'b1, 8'h1c, 32'hffff_ffff, q);
    wb(1'b0, 8'h1c, 32'h0, q);
    check("unmapped", q, 32'h0);
    $display("test registers done");
    // full program, then bypass program, at random words of low sectors
    for (int i = 0; i < 6; i++) begin
      a = {6'h01 + 6'(i), 12'($random(seed))};
      d = 16'($random(seed));
      if (i == 3) cmd(fesc_pkg::FESC_OP_BYP_ENT, 18'h0, 16'h0);
      if (i < 3) cmd(fesc_pkg::FESC_OP_PROGRAM, a, d);
      else cmd(fesc_pkg::FESC_OP_BYP_PRG, a, d);
      check("bypass flag", 32'(st[`FESC_ST_BYPASS]), 32'(i >= 3));
      rd_flash(a, q);
      check("array", q, word_of(d));
    end
    cmd(fesc_pkg::FESC_OP_BYP_EXT, 18'h0, 16'h0);
    check("bypass flag", 32'(st[`FESC_ST_BYPASS]), 32'h0);
    $display("test program done");
    // erase a random upper sector, suspend and work around it
    es = 6'h20 + 6'($random(seed) & 15);
    cmd(fesc_pkg::FESC_OP_SE, {es, 12'h0}, 16'h0);
    cmd(fesc_pkg::FESC_OP_SUSPEND, 18'($random(seed)), 16'h0);
    check("suspended", 32'(st[`FESC_ST_SUSP]), 32'h1);
    rd_flash({es, 12'h123}, q);
    rd_flash({es, 12'h123}, q2);
    check("poll bit", 32'(q[7]), 32'h1);
    check("device toggle", 32'(q[6] ^ q2[6]), 32'h0);
    check("sector toggle", 32'(q[2] ^ q2[2]), 32'h1);
    check("timeout bit", 32'(st[`FESC_ST_TMO]), 32'h0);
    a = {6'h02, 12'($random(seed))};
    d = 16'($random(seed));
    cmd(fesc_pkg::FESC_OP_PROGRAM, a, d);
    rd_flash(a, q);
    check("suspend program", q, word_of(d));
    cmd(fesc_pkg::FESC_OP_AUTOSEL, {es, 12'h002}, 16'h0);
    wb(1'b0, `FESC_REG_RDATA, 32'h0, q);
    check("protect query", q, 32'h0);
    check("autoselect flag", 32'(st[`FESC_ST_AUTOSEL]), 32'h1);
    cmd(fesc_pkg::FESC_OP_RESET, 18'h0, 16'h0);
    check("autoselect flag", 32'(st[`FESC_ST_AUTOSEL]), 32'h0);
    rd_flash({es, 12'h000}, q);
    check("still suspended", 32'(q[7]), 32'h1);
    $display("test suspend done");
    // resume, repeated resume, and a second suspend
    cmd(fesc_pkg::FESC_OP_RESUME, 18'($random(seed)), 16'h0);
    check("suspended", 32'(st[`FESC_ST_SUSP]), 32'h0);
    rd_flash({es, 12'h010}, q);
    rd_flash({es, 12'h010}, q2);
    check("device toggle", 32'(q[6] ^ q2[6]), 32'h1);
    cmd(fesc_pkg::FESC_OP_RESUME, 18'h0, 16'h0);
    cmd(fesc_pkg::FESC_OP_SUSPEND, 18'h0, 16'h0);
    rd_flash({es, 12'h020}, q);
    check("poll bit", 32'(q[7]), 32'h1);
    $display("test resume done");
    print_verdict();
  end
endmodule : fesc_ctrl_tb
